// *** design/tsr_params.svh ***
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
`define TSR_CLK_HZ          40000000
`define TSR_RST_MIN_NS      90
`define TSR_RST_MIN_CYC     (((`TSR_RST_MIN_NS * 40) + 999) / 1000)
`define TSR_HW_READY_MS     47
`define TSR_SW_READY_MS     69
`define TSR_POR_READY_MS    48
`define TSR_PEND_INPUT_MS   100
`define TSR_MS_CYC          (`TSR_CLK_HZ / 1000)
`define TSR_LINE_MAX_MS     2
`define TSR_ACQ_MAX_MS      250
`define TSR_RST_FLAG_BIT    7
`endif

// *** design/tsr_pkg.sv ***
package tsr_pkg;
	typedef enum logic [1:0] {
		TSR_CAUSE_POR,
		TSR_CAUSE_HW,
		TSR_CAUSE_SW
	} tsr_cause_t;
	typedef enum logic [1:0] {
		TSR_BOOT,
		TSR_SLEEP,
		TSR_BURST
	} tsr_scan_t;
endpackage

// *** design/tsr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tsr_link_if;
	logic reset_pin_n;
	logic pend_dev_out;
	logic pend_dev_oe;
	logic pend_host_out;
	logic pend_host_oe;
	logic cmd_reset;
	logic cmd_calibrate;
	logic noise_hint;
	logic [7:0] msg_data;
	logic msg_valid;
	logic msg_ack;
	wire pend_level = (pend_dev_oe && !pend_dev_out) || (pend_host_oe && !pend_host_out)
		? 1'b0 : 1'b1;
	modport device (
		input  reset_pin_n, pend_level, cmd_reset, cmd_calibrate, noise_hint, msg_ack,
		output pend_dev_out, pend_dev_oe, msg_data, msg_valid
	);
	modport host (
		input  pend_level, msg_data, msg_valid,
		output reset_pin_n, pend_host_out, pend_host_oe, cmd_reset, cmd_calibrate,
		noise_hint, msg_ack
	);
endinterface
`default_nettype wire

// *** design/tsr_device.sv ***
`include "tsr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tsr_device #(
	parameter int HW_READY_CYC  = `TSR_HW_READY_MS * `TSR_MS_CYC,
	parameter int SW_READY_CYC  = `TSR_SW_READY_MS * `TSR_MS_CYC,
	parameter int POR_READY_CYC = `TSR_POR_READY_MS * `TSR_MS_CYC,
	parameter int PEND_IN_CYC   = `TSR_PEND_INPUT_MS * `TSR_MS_CYC,
	parameter int ACQ_MAX_CYC   = `TSR_ACQ_MAX_MS * `TSR_MS_CYC,
	parameter int CW            = 24
) (
	// Clock and power-on reset.
	input  wire logic        clk,
	input  wire logic        resetn,
	// Link to the host.
	tsr_link_if.device       link,
	// Configuration.
	input  wire logic        self_test_enable,
	input  wire logic [CW-1:0] idle_cycle_interval,
	input  wire logic [CW-1:0] active_cycle_interval,
	input  wire logic [CW-1:0] active_idle_timeout,
	input  wire logic [CW-1:0] burst_length,
	input  wire logic [7:0]  charge_time_cfg,
	input  wire logic [7:0]  detect_limit,
	input  wire logic        self_cap_enable,
	// Measurement front end.
	input  wire logic        acq_done,
	input  wire logic        mutual_over,
	input  wire logic        mutual_usable,
	input  wire logic        self_over,
	input  wire logic        line_noise_high,
	input  wire logic        recal_request,
	// Status and control to the front end.
	output logic             ready,
	output logic             active_mode,
	output logic             touched,
	output logic             in_burst,
	output logic             signal_error_flag,
	output logic             self_test_run,
	output logic             calibrate,
	output logic             noise_suppress,
	output logic [7:0]       charge_time,
	output logic [7:0]       acq_gain_adj
);
	if (CW < 8 || HW_READY_CYC < 1 || SW_READY_CYC < 1 || POR_READY_CYC < 1
		|| PEND_IN_CYC < 1 || ACQ_MAX_CYC < 1) begin : g_bad_param
		$error("tsr_device: bad parameters");
	end

	logic [2:0] rpin_sync;
	logic [3:0] rlow_cnt;
	logic       pin_reset;
	logic [CW-1:0] boot_cnt;
	logic [CW-1:0] boot_target;
	logic [CW-1:0] pend_in_cnt;
	tsr_pkg::tsr_cause_t cause;
	tsr_pkg::tsr_scan_t  scan;
	logic [CW-1:0] cyc_cnt;
	logic [CW-1:0] idle_cnt;
	logic [CW-1:0] acq_cnt;
	logic [7:0]    det_cnt;
	logic          reset_flag;
	logic          pend_drive;
	logic          msg_valid_r;

	wire pin_low       = !rpin_sync[1];
	wire pin_released  = rpin_sync[2] && rpin_sync[1] && pin_reset;
	wire rlow_done     = (rlow_cnt >= 4'(`TSR_RST_MIN_CYC - 1));
	wire boot_done     = (scan == tsr_pkg::TSR_BOOT) && (boot_cnt >= boot_target);
	wire over          = self_cap_enable && !mutual_usable
		? self_over : mutual_over;
	wire [CW-1:0] cycle_len = active_mode ? active_cycle_interval : idle_cycle_interval;
	wire cycle_end     = (scan == tsr_pkg::TSR_SLEEP) && (cyc_cnt >= cycle_len);
	wire acq_timeout   = (scan == tsr_pkg::TSR_BURST) && (acq_cnt >= CW'(ACQ_MAX_CYC));
	wire any_reset     = pin_released || (link.cmd_reset && scan != tsr_pkg::TSR_BOOT);
	wire pend_in_done  = (pend_in_cnt >= CW'(PEND_IN_CYC));
	wire msg_start     = reset_flag && !msg_valid_r && pend_in_done
		&& (scan != tsr_pkg::TSR_BOOT);

	assign link.pend_dev_out = 1'b0;
	assign link.pend_dev_oe  = pend_drive;
	assign link.msg_valid    = msg_valid_r;
	assign link.msg_data     = {reset_flag, 7'h00};

	always_ff @(posedge clk) begin
		rpin_sync <= {rpin_sync[1], rpin_sync[0], link.reset_pin_n};
		if (!resetn)
			rpin_sync <= 3'h7;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rlow_cnt  <= 4'h0;
			pin_reset <= 1'b0;
		end else if (pin_low) begin
			rlow_cnt <= rlow_done ? rlow_cnt : rlow_cnt + 4'h1;
			if (rlow_done)
				pin_reset <= 1'b1;
		end else begin
			rlow_cnt  <= 4'h0;
			pin_reset <= pin_reset && !pin_released;
		end
	end

	always_comb begin
		unique case (cause)
			tsr_pkg::TSR_CAUSE_POR: boot_target = CW'(POR_READY_CYC);
			tsr_pkg::TSR_CAUSE_HW:  boot_target = CW'(HW_READY_CYC);
			tsr_pkg::TSR_CAUSE_SW:  boot_target = CW'(SW_READY_CYC);
			default:                boot_target = CW'(POR_READY_CYC);
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cause       <= tsr_pkg::TSR_CAUSE_POR;
			scan        <= tsr_pkg::TSR_BOOT;
			boot_cnt    <= '0;
			pend_in_cnt <= '0;
			ready       <= 1'b0;
			reset_flag  <= 1'b0;
			pend_drive  <= 1'b0;
			msg_valid_r <= 1'b0;
			self_test_run <= 1'b0;
		end else if (any_reset || (pin_reset && pin_low)) begin
			cause       <= pin_reset ? tsr_pkg::TSR_CAUSE_HW : tsr_pkg::TSR_CAUSE_SW;
			scan        <= tsr_pkg::TSR_BOOT;
			boot_cnt    <= '0;
			pend_in_cnt <= '0;
			ready       <= 1'b0;
			pend_drive  <= 1'b0;
			msg_valid_r <= 1'b0;
		end else begin
			if (scan == tsr_pkg::TSR_BOOT)
				boot_cnt <= boot_cnt + CW'(1);
			if (!pend_in_done)
				pend_in_cnt <= pend_in_cnt + CW'(1);
			self_test_run <= (scan == tsr_pkg::TSR_BOOT) && (cause == tsr_pkg::TSR_CAUSE_POR)
				&& self_test_enable;
			if (msg_start)
				msg_valid_r <= 1'b1;
			else if (msg_valid_r && link.msg_ack) begin
				msg_valid_r <= 1'b0;
				reset_flag  <= 1'b0;
			end
			if (boot_done) begin
				scan       <= tsr_pkg::TSR_SLEEP;
				ready      <= 1'b1;
				reset_flag <= 1'b1;
			end
			pend_drive <= msg_start || (msg_valid_r && !link.msg_ack);
			if (cycle_end)
				scan <= tsr_pkg::TSR_BURST;
			else if (scan == tsr_pkg::TSR_BURST && (acq_done || acq_timeout))
				scan <= tsr_pkg::TSR_SLEEP;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || scan == tsr_pkg::TSR_BOOT) begin
			cyc_cnt     <= '0;
			acq_cnt     <= '0;
			idle_cnt    <= '0;
			det_cnt     <= 8'h00;
			touched     <= 1'b0;
			active_mode <= 1'b0;
			in_burst    <= 1'b0;
			signal_error_flag <= 1'b0;
		end else begin
			in_burst <= (scan == tsr_pkg::TSR_BURST);
			cyc_cnt  <= cycle_end ? '0 : cyc_cnt + CW'(1);
			acq_cnt  <= (scan == tsr_pkg::TSR_BURST) ? acq_cnt + CW'(1) : '0;
			if (acq_timeout)
				signal_error_flag <= 1'b1;
			else if (link.msg_ack)
				signal_error_flag <= 1'b0;
			if (scan == tsr_pkg::TSR_BURST && acq_done) begin
				if (over) begin
					det_cnt <= (det_cnt >= detect_limit) ? det_cnt : det_cnt + 8'h01;
					touched <= (det_cnt + 8'h01 >= detect_limit);
				end else begin
					det_cnt <= 8'h00;
					touched <= 1'b0;
				end
			end
			if (touched) begin
				active_mode <= 1'b1;
				idle_cnt    <= '0;
			end else if (active_mode) begin
				idle_cnt <= idle_cnt + CW'(1);
				if (idle_cnt >= active_idle_timeout)
					active_mode <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			calibrate      <= 1'b0;
			noise_suppress <= 1'b0;
			charge_time    <= 8'h00;
			acq_gain_adj   <= 8'h00;
		end else begin
			calibrate      <= boot_done || link.cmd_calibrate || recal_request;
			noise_suppress <= link.noise_hint || line_noise_high;
			charge_time    <= charge_time_cfg;
			acq_gain_adj   <= noise_suppress ? charge_time_cfg + 8'h04 : charge_time_cfg;
		end
	end
endmodule
`default_nettype wire

// *** design/tsr_host.sv ***
`include "tsr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tsr_host #(
	parameter int RST_CYC = `TSR_RST_MIN_CYC
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// User side.
	input  wire logic hw_reset_req,
	input  wire logic sw_reset_req,
	input  wire logic calib_req,
	input  wire logic noise_present,
	output logic      msg_seen,
	output logic      reset_seen,
	output logic      pending,
	// Link.
	tsr_link_if.host  link
);
	if (RST_CYC < `TSR_RST_MIN_CYC || RST_CYC > 255) begin : g_bad_param
		$error("tsr_host: reset pulse length out of range");
	end

	logic [7:0] rcnt;
	logic [1:0] psync;
	logic       rpin;
	logic       cmd_r;
	logic       cal_r;
	logic       ack_r;

	assign link.reset_pin_n   = rpin;
	assign link.pend_host_out = 1'b1;
	assign link.pend_host_oe  = 1'b0;
	assign link.cmd_reset     = cmd_r;
	assign link.cmd_calibrate = cal_r;
	assign link.noise_hint    = noise_present;
	assign link.msg_ack       = ack_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			psync <= 2'h3;
			rcnt  <= 8'h00;
			rpin  <= 1'b1;
			cmd_r <= 1'b0;
			cal_r <= 1'b0;
			ack_r <= 1'b0;
			msg_seen   <= 1'b0;
			reset_seen <= 1'b0;
			pending    <= 1'b0;
		end else begin
			psync <= {psync[0], link.pend_level};
			pending <= !psync[1];
			if (hw_reset_req && rpin) begin
				rpin <= 1'b0;
				rcnt <= 8'(RST_CYC);
			end else if (!rpin) begin
				rcnt <= rcnt - 8'h01;
				if (rcnt <= 8'h01)
					rpin <= 1'b1;
			end
			cmd_r <= sw_reset_req;
			cal_r <= calib_req;
			ack_r <= link.msg_valid && !ack_r;
			msg_seen <= link.msg_valid && !ack_r;
			if (link.msg_valid && !ack_r)
				reset_seen <= link.msg_data[`TSR_RST_FLAG_BIT];
		end
	end
endmodule
`default_nettype wire

// *** tb/tsr_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_props (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Link.
	input wire logic reset_pin_n,
	input wire logic pend_dev_out,
	input wire logic pend_dev_oe,
	input wire logic pend_host_oe,
	input wire logic cmd_reset,
	input wire logic msg_valid,
	input wire logic msg_ack
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_rst_len;
		$fell(reset_pin_n) |-> !reset_pin_n [*4];
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
	property p_boot_in;
		$rose(reset_pin_n) |-> ##4 !pend_dev_oe [*8];
	endproperty
	a_boot_in: assert property (p_boot_in) else $error("line driven in boot");
	property p_host_off;
		!pend_host_oe;
	endproperty
	a_host_off: assert property (p_host_off) else $error("host drives line");
	property p_low_only;
		pend_dev_oe |-> !pend_dev_out;
	endproperty
	a_low_only: assert property (p_low_only) else $error("line driven high");
	property p_pend;
		$rose(msg_valid) |-> ##[0:2] pend_dev_oe;
	endproperty
	a_pend: assert property (p_pend) else $error("no pending after message");
	property p_hold;
		msg_valid && !msg_ack |=> msg_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("message dropped");
	property p_ack;
		msg_ack |-> msg_valid ##1 (!msg_ack && !msg_valid);
	endproperty
	a_ack: assert property (p_ack) else $error("ack misbehaves");
	property p_cmd;
		cmd_reset |=> !cmd_reset;
	endproperty
	a_cmd: assert property (p_cmd) else $error("reset command not a pulse");
	c_ack: cover property (msg_ack);
	c_cmd: cover property (cmd_reset);
	c_pin: cover property ($fell(reset_pin_n));
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
`define WT(c) begin k = 0; while (!(c) && k < 400) begin @(posedge clk); #2; k++; end \
	if (k >= 400) begin fail_count++; end_of_test; end end
module tb_top;
	typedef struct {logic hw; int min;} tsr_row_t;
	localparam int HW = 50;
	localparam int SW = 60;
	localparam int POR = 40;
	logic       clk, resetn, hw_req, sw_req, cal_req, noise, pending, ready;
	logic       active_mode, touched, calibrate, noise_sup, acq_done, over, mu;
	logic       st_en, sc_en, s_over, l_noise, recal, in_burst, sig_err, st_run, rst_seen;
	logic [7:0] cfg, lim, charge_time, gain;
	int         fail_count, samples_checked, k;
	tsr_row_t   rows [3] = '{'{1'b1, HW}, '{1'b0, SW}, '{1'b1, HW}};
	tsr_link_if i_tsr_link_if ();
	tsr_device #(.HW_READY_CYC(HW), .SW_READY_CYC(SW), .POR_READY_CYC(POR),
		.PEND_IN_CYC(50), .ACQ_MAX_CYC(50)) i_tsr_device (.clk(clk), .resetn(resetn),
		.link(i_tsr_link_if), .self_test_enable(st_en), .idle_cycle_interval(24'h14),
		.active_cycle_interval(24'h0A), .active_idle_timeout(24'h1E),
		.burst_length(24'h04), .charge_time_cfg(cfg), .detect_limit(lim),
		.self_cap_enable(sc_en), .acq_done(acq_done), .mutual_over(over),
		.mutual_usable(mu), .self_over(s_over), .line_noise_high(l_noise),
		.recal_request(recal), .ready(ready), .active_mode(active_mode), .touched(touched),
		.in_burst(in_burst), .signal_error_flag(sig_err), .self_test_run(st_run),
		.calibrate(calibrate), .noise_suppress(noise_sup), .charge_time(charge_time),
		.acq_gain_adj(gain));
	tsr_host i_tsr_host (.clk(clk), .resetn(resetn), .hw_reset_req(hw_req),
		.sw_reset_req(sw_req), .calib_req(cal_req), .noise_present(noise),
		.msg_seen(), .reset_seen(rst_seen), .pending(pending), .link(i_tsr_link_if));
	tsr_props i_tsr_props (.clk(clk), .resetn(resetn),
		.reset_pin_n(i_tsr_link_if.reset_pin_n), .pend_dev_out(i_tsr_link_if.pend_dev_out),
		.pend_dev_oe(i_tsr_link_if.pend_dev_oe), .pend_host_oe(i_tsr_link_if.pend_host_oe),
		.cmd_reset(i_tsr_link_if.cmd_reset), .msg_valid(i_tsr_link_if.msg_valid),
		.msg_ack(i_tsr_link_if.msg_ack));
	always #12.5 clk = ~clk;
	task end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk);
		#2 s = 1;
		@(posedge clk);
		#2 s = 0;
	endtask
	task automatic boot(input int min);
		int n;
		`WT(!ready)
		n = k;
		`WT(ready)
		n += k;
		`CHK("boot_len", 1'b1, n >= min)
		`WT(i_tsr_link_if.pend_level === 1'b0)
		`CHK("reset_flag", 1'b1, i_tsr_link_if.msg_data[7])
		`WT(!i_tsr_link_if.msg_valid)
		`WT(pending === 1'b1)
		`CHK("reset_seen", 1'b1, rst_seen)
	endtask
	task automatic acq(input logic o);
		`WT(!in_burst)
		`WT(in_burst === 1'b1)
		over = o;
		acq_done = 1;
		@(posedge clk);
		#2 acq_done = 0;
		repeat (3) @(posedge clk);
		#2;
	endtask
	initial begin
		{clk, resetn, hw_req, sw_req, cal_req, noise, acq_done, over} = '0;
		{sc_en, s_over, l_noise, recal} = '0;
		cfg = 8'h10;
		lim = 8'h03;
		mu = 1;
		st_en = 1;
		repeat (4) @(posedge clk);
		#2 resetn = 1;
		repeat (2) @(posedge clk);
		#2;
		`CHK("self_test", 1'b1, st_run)
		boot(POR - 1);
		$display("test power-on boot done");
		foreach (rows[i]) begin
			if (rows[i].hw)
				pulse(hw_req);
			else
				pulse(sw_req);
			boot(rows[i].min);
			$display("test reset row %0d done", i);
		end
		`WT(sig_err === 1'b1)
		`CHK("sig_err", 1'b1, sig_err)
		$display("test acquisition timeout done");
		acq(1);
		acq(1);
		acq(0);
		acq(1);
		acq(1);
		`CHK("touched", 1'b0, touched)
		acq(1);
		`CHK("touched", 1'b1, touched)
		`CHK("active", 1'b1, active_mode)
		$display("test integrator done");
		sc_en = 1;
		mu = 0;
		acq(1);
		`CHK("touched", 1'b0, touched)
		`CHK("active", 1'b1, active_mode)
		`WT(active_mode === 1'b0)
		s_over = 1;
		repeat (3) acq(0);
		`CHK("touched", 1'b1, touched)
		$display("test self data and idle done");
		noise = 1;
		`WT(noise_sup === 1'b1)
		@(posedge clk);
		#2;
		`CHK("gain", cfg + 8'h04, gain)
		`CHK("charge", cfg, charge_time)
		noise = 0;
		l_noise = 1;
		repeat (2) @(posedge clk);
		#2;
		`CHK("noise_line", 1'b1, noise_sup)
		l_noise = 0;
		repeat (2) @(posedge clk);
		#2;
		`CHK("noise_off", 1'b0, noise_sup)
		pulse(cal_req);
		`WT(calibrate === 1'b1)
		`CHK("calibrate", 1'b1, calibrate)
		pulse(recal);
		`WT(calibrate === 1'b1)
		$display("test noise and calibration done");
		st_en = 0;
		@(posedge clk);
		#2 resetn = 0;
		repeat (4) @(posedge clk);
		#2 resetn = 1;
		`CHK("ready", 1'b0, ready)
		repeat (2) @(posedge clk);
		#2;
		`CHK("self_test", 1'b0, st_run)
		boot(POR - 1);
		$display("test mid-run reset done");
		end_of_test;
	end
endmodule
`default_nettype wire
